/* hdl/mmdia_pkg.sv */
/*
  Constants for the indirect extended register access block.
  Assumes a 32-bit classic Wishbone slave on one 100 MHz clock.
*/
// Behaviour
// - Control 0x1F: data-register writes load and keep reloading the pointer.
// - Control 0x1: pointer access for the PMA extended space.
// - Address function: data-register reads return the pointer itself.
// - Control 0x401F: data-register accesses reach the pointed register, pointer kept.
// - No-increment data function: repeated writes hit the same register.
// - No-increment data function: repeated reads return the same register.
// - Control 0x4001: non-incrementing data access to the pointed PMA register.
// - Control 0x801F: pointer increments after every read and every write.
// - Incrementing data function: each further write lands one address higher.
// - Function 10: each further read returns the next higher register.
// - Control 0xC01F: pointer increments after writes.
// - PMA controls 0x8001 and 0xC001 behave like the general ones.
// - Function 11: reads leave the pointer unchanged.
// - Accesses with an unsupported space select are ignored.
// - Control at register 0xD, address/data at 0xE; function 15:14, select 4:0.
package mmdia_pkg;

  // Bus geometry
  localparam int unsigned WB_ADR_W = 8;
  localparam int unsigned WB_DAT_W = 32;
  localparam int unsigned WB_SEL_W = 4;
  localparam int unsigned REG_W    = 16;
  localparam int unsigned PTR_W    = 16;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_ACCESS_CONTROL = 6'h0D;
  localparam logic [5:0] IDX_ADDRESS_DATA   = 6'h0E;
  localparam logic [5:0] IDX_STATUS         = 6'h10;

  // Control register fields
  localparam int unsigned FUNC_HI = 15;
  localparam int unsigned FUNC_LO = 14;
  localparam int unsigned SEL_HI  = 4;
  localparam int unsigned SEL_LO  = 0;

  // Status register fields
  localparam int unsigned ST_PTR_LO  = 0;
  localparam int unsigned ST_FUNC_LO = 16;
  localparam int unsigned ST_VALID   = 18;
  localparam int unsigned ST_PMA     = 19;

  // Supported space selects
  localparam logic [4:0] SPACE_GENERAL = 5'h1F;
  localparam logic [4:0] SPACE_PMA     = 5'h01;

  // Reset values
  localparam logic [REG_W-1:0] CONTROL_RESET = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_RESET     = 16'h0000;

  typedef enum logic [1:0] {
    FN_ADDRESS     = 2'b00,
    FN_DATA        = 2'b01,
    FN_DATA_INC_RW = 2'b10,
    FN_DATA_INC_WR = 2'b11
  } mmdia_func_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } mmdia_bus_t;

endpackage : mmdia_pkg

/* hdl/mmdia_ptr.sv */
/*
  Extended address pointer with load and post-increment.
  Assumes load and increment are never requested in the same cycle.
*/
`timescale 1ns/1ps
module mmdia_ptr (
  input  wire logic                         clk,     // System clock
  input  wire logic                         rst_n,   // Synchronous reset, low
  input  wire logic                         load,    // Load new pointer value
  input  wire logic [mmdia_pkg::PTR_W-1:0]  load_val, // Value to load
  input  wire logic                         inc,     // Post-increment strobe
  output logic      [mmdia_pkg::PTR_W-1:0]  ptr      // Current pointer
);

  // Load from the bus, or advance; width-limited add wraps at the top
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr <= mmdia_pkg::PTR_RESET;
    end else if (load) begin
      ptr <= load_val;
    end else if (inc) begin
      ptr <= ptr + 16'h0001;
    end
  end

endmodule : mmdia_ptr

/* hdl/mmdia_ext_regs.sv */
/*
  Storage for the general and PMA extended register spaces.
  Assumes the caller gates writes with the space select already decoded.
*/
`timescale 1ns/1ps
module mmdia_ext_regs #(
  parameter int unsigned ADDR_W = 6 // Implemented words per space: 2**ADDR_W
) (
  input  wire logic                         clk,      // System clock
  input  wire logic                         rst_n,    // Synchronous reset, low
  input  wire logic                         wr_en,    // Write strobe
  input  wire logic                         pma,      // Space: 1 PMA, 0 general
  input  wire logic [ADDR_W-1:0]            addr,     // Word within the space
  input  wire logic [mmdia_pkg::REG_W-1:0]  wr_data,  // Data to store
  output logic      [mmdia_pkg::REG_W-1:0]  rd_data   // Stored word, combinational
);

  localparam int unsigned DEPTH = 1 << ADDR_W;

  logic [mmdia_pkg::REG_W-1:0] general_mem [DEPTH];
  logic [mmdia_pkg::REG_W-1:0] pma_mem     [DEPTH];

  // Cleared on reset so reads never return unknowns
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        general_mem[i] <= '0;
        pma_mem[i]     <= '0;
      end
    end else if (wr_en) begin
      if (pma) begin
        pma_mem[addr] <= wr_data;
      end else begin
        general_mem[addr] <= wr_data;
      end
    end
  end

  assign rd_data = pma ? pma_mem[addr] : general_mem[addr];

endmodule : mmdia_ext_regs

/* hdl/mmdia_top.sv */
/*
  Indirect access to extended register spaces through a control
  register and an address/data register, as a classic Wishbone slave.
  Assumes a single-cycle classic master that holds each request until
  it sees ack and then drops cyc and stb for at least one cycle.
*/
`timescale 1ns/1ps
module mmdia_top #(
  parameter int unsigned EXT_ADDR_W = 6 // Implemented extended words per space: 2**EXT_ADDR_W
) (
  input  wire logic                            clk,          // 100 MHz clock
  input  wire logic                            rst_n,        // Sync reset, low
  input  wire logic                            wb_cyc_i,     // Bus cycle
  input  wire logic                            wb_stb_i,     // Strobe
  input  wire logic                            wb_we_i,      // Write enable
  input  wire logic [mmdia_pkg::WB_ADR_W-1:0]  wb_adr_i,     // Byte address
  input  wire logic [mmdia_pkg::WB_SEL_W-1:0]  wb_sel_i,     // Byte lanes
  input  wire logic [mmdia_pkg::WB_DAT_W-1:0]  wb_dat_i,     // Write data
  output logic      [mmdia_pkg::WB_DAT_W-1:0]  wb_dat_o,     // Read data
  output logic                                 wb_ack_o,     // Acknowledge
  output logic                                 ext_wr_valid, // Extended write pulse
  output logic                                 ext_wr_pma,   // Written space is PMA
  output logic      [mmdia_pkg::PTR_W-1:0]     ext_wr_addr,  // Written address
  output logic      [mmdia_pkg::REG_W-1:0]     ext_wr_data,  // Written value
  output logic      [mmdia_pkg::PTR_W-1:0]     ptr_out       // Pointer mirror
);

  // Parameter sanity: storage cannot exceed what the pointer reaches
  if (EXT_ADDR_W < 1 || EXT_ADDR_W > mmdia_pkg::PTR_W) begin : g_bad_width
    $error("EXT_ADDR_W must lie between 1 and the pointer width");
  end

  // Helpers below assume 16-bit registers in the low half of a 32-bit bus
  if (mmdia_pkg::REG_W != 16 || mmdia_pkg::WB_DAT_W != 32) begin : g_bad_bus
    $error("Register and bus widths must be 16 and 32 bits");
  end

  // One pointer feeds the load and data paths, so it is one register wide
  if (mmdia_pkg::PTR_W != mmdia_pkg::REG_W) begin : g_bad_ptr
    $error("Pointer width must equal the register width");
  end

  // Byte addresses are six index bits above two lane bits
  if (mmdia_pkg::WB_ADR_W != 8 || mmdia_pkg::WB_SEL_W != 4) begin : g_bad_adr
    $error("Byte address must be 8 bits and lane select 4 bits");
  end

  // Aliased registers would both react to one access
  if (mmdia_pkg::IDX_ACCESS_CONTROL == mmdia_pkg::IDX_ADDRESS_DATA
      || mmdia_pkg::IDX_STATUS == mmdia_pkg::IDX_ACCESS_CONTROL
      || mmdia_pkg::IDX_STATUS == mmdia_pkg::IDX_ADDRESS_DATA) begin : g_bad_idx
    $error("Register indices must be distinct");
  end

  // Control layout: two function bits above a five-bit space select
  if (mmdia_pkg::FUNC_HI != mmdia_pkg::FUNC_LO + 1
      || mmdia_pkg::SEL_HI != mmdia_pkg::SEL_LO + 4
      || mmdia_pkg::FUNC_LO <= mmdia_pkg::SEL_HI
      || mmdia_pkg::FUNC_HI >= mmdia_pkg::REG_W) begin : g_bad_fields
    $error("Function and space select fields do not fit the control register");
  end

  // The two served spaces must decode apart
  if (mmdia_pkg::SPACE_GENERAL == mmdia_pkg::SPACE_PMA) begin : g_bad_space
    $error("General and PMA space selects must differ");
  end

  // Status layout: pointer below the function field, flags above it
  if (mmdia_pkg::ST_FUNC_LO < mmdia_pkg::ST_PTR_LO + mmdia_pkg::PTR_W
      || mmdia_pkg::ST_VALID < mmdia_pkg::ST_FUNC_LO + 2
      || mmdia_pkg::ST_PMA >= mmdia_pkg::WB_DAT_W) begin : g_bad_status
    $error("Status fields overlap or exceed the bus word");
  end

  // Short local names for the package widths
  localparam int unsigned REG_W = mmdia_pkg::REG_W;
  localparam int unsigned PTR_W = mmdia_pkg::PTR_W;
  localparam int unsigned DAT_W = mmdia_pkg::WB_DAT_W;

  // Byte address of a register index
  function automatic logic [mmdia_pkg::WB_ADR_W-1:0] reg_addr(
    input logic [5:0] idx
  );
    reg_addr = {idx, 2'b00};
  endfunction : reg_addr

  // Merge a write into a 16-bit register by byte lanes
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0]  lanes
  );
    lane_merge = old_val;
    if (lanes[0]) begin
      lane_merge[7:0] = new_val[7:0];
    end
    if (lanes[1]) begin
      lane_merge[15:8] = new_val[15:8];
    end
  endfunction : lane_merge

  // Widen a 16-bit register to a bus word with zero upper bits
  function automatic logic [31:0] widen(
    input logic [15:0] val
  );
    widen = {16'h0000, val};
  endfunction : widen

  // Access flow: software sets the control register, then uses the address/data
  // register. The address function loads or returns the pointer; the data
  // functions reach the pointed word in the selected space and may advance the
  // pointer once the access is over. Only the general and PMA spaces are served;
  // accesses under any other select are acknowledged and otherwise ignored.
  // Registers and state
  mmdia_pkg::mmdia_bus_t      bus_state_reg;
  logic [REG_W-1:0]           control_reg;
  logic [DAT_W-1:0]           rdata_reg;
  logic                       ext_wr_valid_reg;
  logic                       ext_wr_pma_reg;
  logic [PTR_W-1:0]           ext_wr_addr_reg;
  logic [REG_W-1:0]           ext_wr_data_reg;
  logic [PTR_W-1:0]           ptr_out_reg;

  // Pointer and storage interface
  logic [PTR_W-1:0]           ptr;
  logic                       ptr_load;
  logic [PTR_W-1:0]           ptr_load_val;
  logic                       ptr_inc;
  logic                       ext_wr_en;
  logic [REG_W-1:0]           ext_rd_data;
  logic [REG_W-1:0]           ext_wr_word;
  logic                       ext_in_range;

  // Request decode
  logic                       req;
  logic                       wr_req;
  logic                       rd_req;
  logic                       hit_control;
  logic                       hit_addr_data;
  logic                       hit_status;
  logic [1:0]                 lanes;
  logic [REG_W-1:0]           wdata16;

  // Control fields
  mmdia_pkg::mmdia_func_t     func;
  logic [4:0]                 space_sel;
  logic                       space_ok;
  logic                       space_pma;
  logic                       data_mode;
  logic [REG_W-1:0]           data_read;
  logic [DAT_W-1:0]           status_word;

  // A request is taken only from idle, so the held cycle is not retaken
  assign req    = wb_cyc_i && wb_stb_i && (bus_state_reg == mmdia_pkg::BUS_IDLE);
  assign wr_req = req && wb_we_i;
  assign rd_req = req && !wb_we_i;

  // Address decode; registers sit at four times their index
  assign hit_control   = (wb_adr_i == reg_addr(mmdia_pkg::IDX_ACCESS_CONTROL));
  assign hit_addr_data = (wb_adr_i == reg_addr(mmdia_pkg::IDX_ADDRESS_DATA));
  assign hit_status    = (wb_adr_i == reg_addr(mmdia_pkg::IDX_STATUS));

  // Only the low two lanes carry register bits
  assign lanes   = wb_sel_i[1:0];
  assign wdata16 = wb_dat_i[REG_W-1:0];

  // Field extraction from the control register
  assign func      = mmdia_pkg::mmdia_func_t'(
                       control_reg[mmdia_pkg::FUNC_HI:mmdia_pkg::FUNC_LO]);
  assign space_sel = control_reg[mmdia_pkg::SEL_HI:mmdia_pkg::SEL_LO];

  // Only the general and PMA spaces are served
  assign space_pma = (space_sel == mmdia_pkg::SPACE_PMA);
  assign space_ok  = (space_sel == mmdia_pkg::SPACE_GENERAL) || space_pma;
  assign data_mode = (func != mmdia_pkg::FN_ADDRESS);

  // Storage beyond the implemented depth reads zero, drops writes
  // The pointer still advances there, so a wrap stays visible to software
  assign ext_in_range = (ptr >> EXT_ADDR_W) == '0;

  // Address function: a write reloads the pointer, lanes merged
  assign ptr_load     = wr_req && hit_addr_data && space_ok && !data_mode;
  assign ptr_load_val = lane_merge(ptr, wdata16, lanes);

  // Post-increment after the access, by function and direction
  always_comb begin
    ptr_inc = 1'b0;
    if (req && hit_addr_data && space_ok) begin
      case (func)
        mmdia_pkg::FN_ADDRESS:     ptr_inc = 1'b0;
        mmdia_pkg::FN_DATA:        ptr_inc = 1'b0;
        mmdia_pkg::FN_DATA_INC_RW: ptr_inc = 1'b1;
        mmdia_pkg::FN_DATA_INC_WR: ptr_inc = wb_we_i;
        default:                   ptr_inc = 1'b0;
      endcase
    end
  end

  // Data function writes go to the pointed register in the chosen space
  assign ext_wr_en = wr_req && hit_addr_data && space_ok && data_mode
                     && ext_in_range;

  // Partial writes merge with the stored word, so lanes stay independent
  assign ext_wr_word = lane_merge(ext_rd_data, wdata16, lanes);

  // What a read of the address/data register returns
  always_comb begin
    data_read = 16'h0000;
    if (space_ok) begin
      if (!data_mode) begin
        data_read = ptr;
      end else if (ext_in_range) begin
        data_read = ext_rd_data;
      end
    end
  end

  // Status word: pointer, function, space validity and PMA selection
  // Read only; a write to it is acknowledged and changes nothing
  always_comb begin
    status_word = '0;
    status_word[mmdia_pkg::ST_PTR_LO +: PTR_W] = ptr;
    status_word[mmdia_pkg::ST_FUNC_LO +: 2]    = func;
    status_word[mmdia_pkg::ST_VALID]           = space_ok;
    status_word[mmdia_pkg::ST_PMA]             = space_pma;
  end

  // Pointer, shared by both spaces
  mmdia_ptr u_ptr (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (ptr_load),
    .load_val (ptr_load_val),
    .inc      (ptr_inc),
    .ptr      (ptr)
  );

  // Extended storage; a partial write merges with the stored word
  mmdia_ext_regs #(
    .ADDR_W (EXT_ADDR_W)
  ) u_ext_regs (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (ext_wr_en),
    .pma     (space_pma),
    .addr    (ptr[EXT_ADDR_W-1:0]),
    .wr_data (ext_wr_word),
    .rd_data (ext_rd_data)
  );

  // Bus handshake: one ack cycle per request, then back to idle
  // Idle in between, so a request still held while ack stands is not retaken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_state_reg <= mmdia_pkg::BUS_IDLE;
    end else begin
      case (bus_state_reg)
        mmdia_pkg::BUS_IDLE: begin
          if (req) begin
            bus_state_reg <= mmdia_pkg::BUS_ACK;
          end
        end
        mmdia_pkg::BUS_ACK: begin
          bus_state_reg <= mmdia_pkg::BUS_IDLE;
        end
        default: begin
          bus_state_reg <= mmdia_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Control register; always writable so software can leave a bad select
  // Lanes merge, so a low-byte write changes only bits 7:0 and leaves the function bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control_reg <= mmdia_pkg::CONTROL_RESET;
    end else if (wr_req && hit_control) begin
      control_reg <= lane_merge(control_reg, wdata16, lanes);
    end
  end

  // Read data captured at the take edge; unmapped reads give zero
  // Data reads see the pointer before this access advances it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (rd_req) begin
      if (hit_control) begin
        rdata_reg <= widen(control_reg);
      end else if (hit_addr_data) begin
        rdata_reg <= widen(data_read);
      end else if (hit_status) begin
        rdata_reg <= status_word;
      end else begin
        rdata_reg <= '0;
      end
    end
  end

  // Notify the device core of each landed extended write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_wr_valid_reg <= 1'b0;
    end else begin
      ext_wr_valid_reg <= ext_wr_en;
    end
  end

  // Space, address and word of the last landed write, held for the core
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_wr_pma_reg  <= 1'b0;
      ext_wr_addr_reg <= '0;
      ext_wr_data_reg <= '0;
    end else if (ext_wr_en) begin
      ext_wr_pma_reg  <= space_pma;
      ext_wr_addr_reg <= ptr;
      ext_wr_data_reg <= ext_wr_word;
    end
  end

  // Pointer mirror registered so the output stays glitch free
  // Lags the internal pointer by one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_out_reg <= mmdia_pkg::PTR_RESET;
    end else begin
      ptr_out_reg <= ptr;
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o     = (bus_state_reg == mmdia_pkg::BUS_ACK);
  assign wb_dat_o     = rdata_reg;
  assign ext_wr_valid = ext_wr_valid_reg;
  assign ext_wr_pma   = ext_wr_pma_reg;
  assign ext_wr_addr  = ext_wr_addr_reg;
  assign ext_wr_data  = ext_wr_data_reg;
  assign ptr_out      = ptr_out_reg;

endmodule : mmdia_top

/* sim/mmdia_top_asserts.sv */
/*
  Checker for the indirect extended register access block.
  Assumes full-lane 16-bit accesses from a classic single-cycle master.
*/
`timescale 1ns/1ps
module mmdia_checker (
  input wire logic        clk,          // Clock
  input wire logic        rst_n,        // Sync reset, low
  input wire logic        wb_cyc_i,     // Bus cycle
  input wire logic        wb_stb_i,     // Strobe
  input wire logic        wb_we_i,      // Write enable
  input wire logic [7:0]  wb_adr_i,     // Byte address
  input wire logic [31:0] wb_dat_i,     // Write data
  input wire logic [31:0] wb_dat_o,     // Read data
  input wire logic        wb_ack_o,     // Acknowledge
  input wire logic        ext_wr_valid, // Write pulse
  input wire logic        ext_wr_pma,   // Written space
  input wire logic [15:0] ext_wr_addr,  // Written address
  input wire logic [15:0] ext_wr_data,  // Written value
  input wire logic [15:0] ptr_out       // Pointer mirror
);
  logic [15:0] ctl_reg; // Shadow of the control register
  logic        take;
  logic        dr;
  logic        ok;
  // Request decode; held request in the ack cycle is not a new one
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign dr   = take & (wb_adr_i == 8'h38);
  assign ok   = (ctl_reg[4:0] == 5'h1F) | (ctl_reg[4:0] == 5'h01);
  // Shadow only tracks full-lane writes, which is all the bench issues
  always_ff @(posedge clk) begin
    if (!rst_n) ctl_reg <= 16'h0000;
    else if (take & wb_we_i & (wb_adr_i == 8'h34)) ctl_reg <= wb_dat_i[15:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ack; take |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack is not one pulse");
  property p_load; dr & wb_we_i & (ctl_reg[15:14] == 2'b00) & ok
    |-> ##2 ptr_out == $past(wb_dat_i[15:0], 2); endproperty
  a_load: assert property (p_load) else $error("pointer not loaded");
  property p_rdptr; dr & !wb_we_i & (ctl_reg[15:14] == 2'b00) & ok
    |=> wb_dat_o == {16'h0000, ptr_out}; endproperty
  a_rdptr: assert property (p_rdptr) else $error("read is not the pointer");
  property p_ext; dr & wb_we_i & (ctl_reg[15:14] != 2'b00) & ok |=> ext_wr_valid
    && ext_wr_addr == ptr_out && ext_wr_data == $past(wb_dat_i[15:0])
    && ext_wr_pma == !$past(ctl_reg[1]); endproperty
  a_ext: assert property (p_ext) else $error("data write went astray");
  property p_keep; dr & (ctl_reg[15:14] == 2'b01) & ok |-> ##2 $stable(ptr_out); endproperty
  a_keep: assert property (p_keep) else $error("pointer moved");
  property p_inc; dr & ok & ((ctl_reg[15:14] == 2'b10) | (ctl_reg[15:14] == 2'b11) & wb_we_i)
    |-> ##2 ptr_out == 16'($past(ptr_out) + 16'h0001); endproperty
  a_inc: assert property (p_inc) else $error("pointer not advanced");
  property p_hold; dr & ok & !wb_we_i & (ctl_reg[15:14] == 2'b11)
    |-> ##2 $stable(ptr_out); endproperty
  a_hold: assert property (p_hold) else $error("pointer moved on read");
  property p_ign; dr & !ok |=> !ext_wr_valid ##1 $stable(ptr_out); endproperty
  a_ign: assert property (p_ign) else $error("ignored access acted");
  c_inc: cover property (dr & ok & (ctl_reg[15:14] == 2'b10));
  c_load: cover property (dr & wb_we_i & (ctl_reg[15:14] == 2'b00) & ok);
  c_ign: cover property (dr & !ok);
endmodule : mmdia_checker

bind mmdia_top mmdia_checker u_chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_wr_valid(ext_wr_valid),
  .ext_wr_pma(ext_wr_pma), .ext_wr_addr(ext_wr_addr), .ext_wr_data(ext_wr_data),
  .ptr_out(ptr_out));

/* sim/mmdia_mgmt_model.sv */
/*
  Management controller model: a classic Wishbone master.
  Assumes requests start right after a rising edge of clk.
*/
`timescale 1ns/1ps
module mmdia_mgmt_model (
  input  wire logic        clk, // Clock
  output logic             cyc, // Bus cycle
  output logic             stb, // Strobe
  output logic             we,  // Write enable
  output logic [7:0]       adr, // Byte address
  output logic [3:0]       sel, // Byte lanes
  output logic [31:0]      dat, // Write data
  input  wire logic [31:0] dq,  // Read data
  input  wire logic        ack  // Acknowledge
);
  // Idle bus from time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h00000000;
  end
  // Held until ack is sampled; released data flips so stale values never match
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= {16'h0000, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = dq;
    cyc <= 1'b0;
    stb <= 1'b0;
    dat <= ~dat;
    @(posedge clk);
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    acc(1'b0, a, 16'h0000, q);
  endtask : rd
  // Address setup first, then the data function
  task automatic point(input logic [4:0] s, input logic [15:0] p, input logic [1:0] f);
    wr(8'h34, {11'h000, s});
    wr(8'h38, p);
    wr(8'h34, {f, 9'h000, s});
  endtask : point
endmodule : mmdia_mgmt_model

/* sim/testbench.sv */
/*
  Self-checking bench for the indirect access block.
  Assumes the management model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc, stb, we, ack, wv, wp;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] di, dq;
  logic [15:0] wa, wd, po;
  int          n_errors = 0;
  int          comparisons = 0;
  int          n_wr = 0;
  always #5 clk = ~clk;
  // Count landed extended writes
  always @(posedge clk) if (wv === 1'b1) n_wr++;
  mmdia_top #(.EXT_ADDR_W(2)) u_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di),
    .wb_dat_o(dq), .wb_ack_o(ack), .ext_wr_valid(wv), .ext_wr_pma(wp),
    .ext_wr_addr(wa), .ext_wr_data(wd), .ptr_out(po));
  mmdia_mgmt_model u_mgmt (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .dat(di), .dq(dq), .ack(ack));
  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic st(input logic [15:0] e); // Pointer via status
    logic [31:0] q;
    u_mgmt.rd(8'h40, q);
    `CHK(q[15:0], e)
  endtask : st
  task automatic t_reset();
    logic [31:0] q;
    u_mgmt.rd(8'h34, q);
    `CHK(q, 32'h00000000)
    u_mgmt.rd(8'h38, q);
    `CHK(q, 32'h00000000)
    st(16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_noinc();
    logic [31:0] q;
    logic [4:0]  s;
    logic [15:0] v;
    int          w;
    for (int k = 0; k < 2; k++) begin
      s = k ? 5'h01 : 5'h1F;
      v = k ? 16'hBEEF : 16'h1234;
      u_mgmt.point(s, 16'h0002, 2'b00);
      u_mgmt.rd(8'h38, q);
      `CHK(q, 32'h00000002)
      u_mgmt.wr(8'h38, 16'h0001);
      u_mgmt.rd(8'h38, q);
      `CHK(q, 32'h00000001)
      u_mgmt.wr(8'h34, {2'b01, 9'h000, s});
      w = n_wr;
      u_mgmt.wr(8'h38, 16'hFFFF);
      u_mgmt.wr(8'h38, v);
      `CHK(n_wr - w, 2)
      `CHK(wa, 16'h0001)
      `CHK(wp, k[0])
      repeat (2) begin
        u_mgmt.rd(8'h38, q);
        `CHK(q, {16'h0000, v})
      end
      u_mgmt.rd(8'h40, q);
      `CHK(q, k ? 32'h000D0001 : 32'h00050001)
      `CHK(wd, v)
      `CHK(po, 16'h0001)
    end
    u_mgmt.wr(8'h34, 16'h401F);
    u_mgmt.rd(8'h38, q);
    `CHK(q, 32'h00001234)
    $display("test noinc done");
  endtask : t_noinc
  task automatic t_inc();
    logic [31:0] q;
    logic [4:0]  s;
    for (int k = 0; k < 2; k++) begin
      s = k ? 5'h01 : 5'h1F;
      u_mgmt.point(s, 16'h0000, 2'b10);
      for (int i = 0; i < 3; i++) u_mgmt.wr(8'h38, 16'h0100 + i[15:0]);
      `CHK(wa, 16'h0002)
      st(16'h0003);
      u_mgmt.point(s, 16'h0000, 2'b10);
      for (int i = 0; i < 3; i++) begin
        u_mgmt.rd(8'h38, q);
        `CHK(q, 32'h00000100 + i)
      end
      u_mgmt.point(s, 16'h0000, 2'b11);
      repeat (2) begin
        u_mgmt.rd(8'h38, q);
        `CHK(q, 32'h00000100)
      end
      st(16'h0000);
      u_mgmt.wr(8'h38, 16'h0200);
      st(16'h0001);
      u_mgmt.rd(8'h38, q);
      `CHK(q, 32'h00000101)
    end
    $display("test inc done");
  endtask : t_inc
  task automatic t_edge();
    logic [31:0] q;
    int          w;
    u_mgmt.point(5'h1F, 16'h0003, 2'b01);
    u_mgmt.wr(8'h34, 16'h4003);
    w = n_wr;
    u_mgmt.wr(8'h38, 16'h7777);
    u_mgmt.rd(8'h38, q);
    `CHK(q, 32'h00000000)
    `CHK(n_wr - w, 0)
    u_mgmt.rd(8'h40, q);
    `CHK(q, 32'h00010003)
    u_mgmt.rd(8'h34, q);
    `CHK(q, 32'h00004003)
    u_mgmt.rd(8'h3C, q);
    `CHK(q, 32'h00000000)
    u_mgmt.point(5'h1F, 16'hFFFF, 2'b10);
    u_mgmt.rd(8'h38, q);
    `CHK(q, 32'h00000000)
    st(16'h0000);
    $display("test edge done");
  endtask : t_edge
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_noinc();
    t_inc();
    t_edge();
    finish_test();
  end
endmodule : testbench
